// *** mpio_pkg.sv ***
// Package for the parallel I/O port block: register offsets, pin masks,
// reset values and the pull-up group map. Assumes an 8-bit register port.
package mpio_pkg;

	// ****************************************************************
	// Port layout
	// ****************************************************************
	localparam int NUM_PORTS = 9;
	localparam int PORT_W = 8;
	// Port numbers held at each index: 0,1,2,3,7,8,9,10,11
	localparam logic [7:0] PORT_NUMBER [NUM_PORTS] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B};
	// Pins that exist on each port
	localparam logic [7:0] PIN_MASK [NUM_PORTS] = '{8'hBF, 8'hFF, 8'hE0, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h0F, 8'hFF};
	// Pins that can drive (port 0 pins 0 and 7 are input only)
	localparam logic [7:0] DRIVE_MASK [NUM_PORTS] = '{8'h3E, 8'hFF, 8'hE0, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h0F, 8'hFF};
	// Pull-up group: bit of option register low (0) or high (1)
	localparam logic PUO_SEL [NUM_PORTS] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	localparam logic [2:0] PUO_BIT [NUM_PORTS] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
	localparam int IDX_PORT8 = 5;
	localparam int IDX_PORT9 = 6;
	localparam int IDX_PORT11 = 8;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_DATA_BASE = 8'h00;
	localparam logic [7:0] OFS_DIR_BASE = 8'h10;
	localparam logic [7:0] OFS_PULLUP_LOW = 8'h20;
	localparam logic [7:0] OFS_PULLUP_HIGH = 8'h21;
	localparam logic [7:0] OFS_KEY_MODE = 8'h22;
	localparam logic [7:0] OFS_LCD_CTRL = 8'h23;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h25;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h26;

	// ****************************************************************
	// Interrupt status layout and reset values
	// ****************************************************************
	localparam int IRQ_EXT_LSB = 0;
	localparam int IRQ_EXT_W = 6;
	localparam int IRQ_KEY_BIT = 6;
	localparam int IRQ_W = 7;
	localparam logic [7:0] RST_DIR = 8'hFF;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_ZERO = 8'h00;

endpackage : mpio_pkg

// *** mpio_ports.sv ***
// Parallel I/O ports: output latches, direction and pull-up control,
// segment/IO sharing on ports 8 and 9, edge flags and an interrupt line.
// Assumes pins come from outside the clock domain and segment data from
// on-chip logic on clk.
//
// Notes on behaviour
// - Port 0 has seven pins, drivable ones backed by an output latch.
// - Port 0 pins 1..5 pick input or output per bit from direction group 0.
// - Port 0 pins 0 and 7 are input only, no driver, no direction.
// - One low pull-up option bit enables pull-ups of port 0 pins 1..5 in input mode.
// - Reset puts every port 0 pin in input mode.
// - A changing level on a port 0 output pin sets its interrupt flag.
// - Port 1 is eight bidirectional pins with an output latch.
// - Port 1 direction is chosen per pin by direction group 1.
// - One low pull-up option bit enables pull-ups of port 1 input pins.
// - Reset puts every port 1 pin in input mode.
// - LCD control gives ports 8 and 9 pin pairs to segments or I/O.
// - Falling edges on port 11 inputs are detected.
// - There are 57 pins: two input only and 55 bidirectional.
// - Every bidirectional pin has a software-enabled pull-up, none fixed on.
// - All direction registers reset to all ones, so pins start as inputs.
// - A port 11 falling edge sets the key return interrupt flag.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps

module mpio_ports #(
	parameter int NUM_PORTS = mpio_pkg::NUM_PORTS,
	parameter int PORT_W = mpio_pkg::PORT_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	output logic [NUM_PORTS*PORT_W-1:0] pin_out,
	output logic [NUM_PORTS*PORT_W-1:0] pin_oe,
	output logic [NUM_PORTS*PORT_W-1:0] pullup_en,
	input wire logic [2*PORT_W-1:0] seg_data,
	output logic irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] data_latch [NUM_PORTS];
	logic [7:0] direction_reg_n [NUM_PORTS];
	logic [7:0] pullup_option_low;
	logic [7:0] pullup_option_high;
	logic [7:0] key_return_mode_reg;
	logic [7:0] lcd_ctrl;
	logic [mpio_pkg::IRQ_W-1:0] irq_status;
	logic [mpio_pkg::IRQ_W-1:0] irq_enable;
	logic [NUM_PORTS*PORT_W-1:0] pin_meta;
	logic [NUM_PORTS*PORT_W-1:0] pin_sync;
	logic [7:0] key_prev;
	logic [mpio_pkg::IRQ_EXT_W-1:0] ext_prev;
	logic [7:0] level [NUM_PORTS];
	logic [mpio_pkg::IRQ_EXT_W-1:0] ext_level;
	logic [mpio_pkg::IRQ_EXT_W-1:0] ext_event;
	logic key_event;
	logic [NUM_PORTS*PORT_W-1:0] next_pin_out;
	logic [NUM_PORTS*PORT_W-1:0] next_pin_oe;
	logic [NUM_PORTS*PORT_W-1:0] next_pullup_en;
	logic [7:0] next_rdata;

	// Address hits register offset base + index
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
		hit = (a == 8'(base + 8'(idx)));
	endfunction : hit

	// Group pull-up enable for a port index
	function automatic logic group_pullup(input int idx, input logic [7:0] low, input logic [7:0] high);
		group_pullup = mpio_pkg::PUO_SEL[idx] ? high[mpio_pkg::PUO_BIT[idx]] : low[mpio_pkg::PUO_BIT[idx]];
	endfunction : group_pullup

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	// Two flops before any logic looks at a pin
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************************************
	// Output latches and direction registers
	// ****************************************************************
	// Writes always update the latch, whatever the direction
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				data_latch[i] <= mpio_pkg::RST_DATA;
			end
		end else if (wr) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (hit(addr, mpio_pkg::OFS_DATA_BASE, i)) begin
					data_latch[i] <= wdata & mpio_pkg::DRIVE_MASK[i];
				end
			end
		end
	end

	// Direction: one means input; reset makes every pin an input
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				direction_reg_n[i] <= mpio_pkg::RST_DIR;
			end
		end else if (wr) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				if (hit(addr, mpio_pkg::OFS_DIR_BASE, i)) begin
					// Input-only pins stay fixed at input
					direction_reg_n[i] <= wdata | ~mpio_pkg::DRIVE_MASK[i];
				end
			end
		end
	end

	// ****************************************************************
	// Option registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			pullup_option_low <= mpio_pkg::RST_ZERO;
			pullup_option_high <= mpio_pkg::RST_ZERO;
			key_return_mode_reg <= mpio_pkg::RST_ZERO;
			lcd_ctrl <= mpio_pkg::RST_ZERO;
			irq_enable <= '0;
		end else if (wr) begin
			if (addr == mpio_pkg::OFS_PULLUP_LOW) begin
				pullup_option_low <= wdata;
			end
			if (addr == mpio_pkg::OFS_PULLUP_HIGH) begin
				pullup_option_high <= wdata;
			end
			if (addr == mpio_pkg::OFS_KEY_MODE) begin
				key_return_mode_reg <= wdata;
			end
			if (addr == mpio_pkg::OFS_LCD_CTRL) begin
				lcd_ctrl <= wdata;
			end
			if (addr == mpio_pkg::OFS_IRQ_ENABLE) begin
				irq_enable <= wdata[mpio_pkg::IRQ_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Pin level seen by software and by the port 0 change detector
	// ****************************************************************
	// Input pins show the pin, output pins show the latch
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			level[i] = ((direction_reg_n[i] & pin_sync[i*PORT_W +: PORT_W])
				| (~direction_reg_n[i] & data_latch[i])) & mpio_pkg::PIN_MASK[i];
		end
		ext_level = level[0][mpio_pkg::IRQ_EXT_W-1:0];
	end

	// ****************************************************************
	// Event detection
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_prev <= '0;
			key_prev <= mpio_pkg::RST_DIR;
		end else begin
			ext_prev <= ext_level;
			key_prev <= pin_sync[mpio_pkg::IDX_PORT11*PORT_W +: PORT_W];
		end
	end

	// Any change on port 0 pins 0 to 5, also one driven by its own latch
	assign ext_event = ext_level ^ ext_prev;
	// Falling edge on an enabled port 11 pin
	assign key_event = |(key_prev & ~pin_sync[mpio_pkg::IDX_PORT11*PORT_W +: PORT_W]
		& key_return_mode_reg);

	// ****************************************************************
	// Interrupt status, clear and output
	// ****************************************************************
	// Sticky bits; a new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~((wr && addr == mpio_pkg::OFS_IRQ_CLEAR) ?
				wdata[mpio_pkg::IRQ_W-1:0] : '0))
				| {key_event, ext_event};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ****************************************************************
	// Pin drive and pull-ups
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			for (int j = 0; j < PORT_W; j++) begin
				// Only pins that can drive get a driver and a pull-up
				next_pin_oe[i*PORT_W+j] = mpio_pkg::DRIVE_MASK[i][j] & ~direction_reg_n[i][j];
				next_pin_out[i*PORT_W+j] = next_pin_oe[i*PORT_W+j] & data_latch[i][j];
				next_pullup_en[i*PORT_W+j] = mpio_pkg::DRIVE_MASK[i][j] & direction_reg_n[i][j]
					& group_pullup(i, pullup_option_low, pullup_option_high);
			end
		end
		// Segment mode takes pin pairs of ports 8 and 9
		for (int g = 0; g < 8; g++) begin
			if (lcd_ctrl[g]) begin
				for (int k = 0; k < 2; k++) begin
					next_pin_oe[mpio_pkg::IDX_PORT8*PORT_W+2*g+k] = 1'b1;
					next_pin_out[mpio_pkg::IDX_PORT8*PORT_W+2*g+k] = seg_data[2*g+k];
					next_pullup_en[mpio_pkg::IDX_PORT8*PORT_W+2*g+k] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_out <= '0;
			pin_oe <= '0;
			pullup_en <= '0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			pullup_en <= next_pullup_en;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_comb begin
		next_rdata = 8'h00;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (hit(addr, mpio_pkg::OFS_DATA_BASE, i)) begin
				next_rdata = level[i];
			end
			if (hit(addr, mpio_pkg::OFS_DIR_BASE, i)) begin
				next_rdata = direction_reg_n[i];
			end
		end
		case (addr)
			mpio_pkg::OFS_PULLUP_LOW: next_rdata = pullup_option_low;
			mpio_pkg::OFS_PULLUP_HIGH: next_rdata = pullup_option_high;
			mpio_pkg::OFS_KEY_MODE: next_rdata = key_return_mode_reg;
			mpio_pkg::OFS_LCD_CTRL: next_rdata = lcd_ctrl;
			mpio_pkg::OFS_IRQ_STATUS: next_rdata = {1'b0, irq_status};
			mpio_pkg::OFS_IRQ_ENABLE: next_rdata = {1'b0, irq_enable};
			default: ;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end

endmodule : mpio_ports

// *** mpio_props.sv ***
// Checker for the parallel port block.
// Assumes it is bound to mpio_ports and sees only its ports.
`timescale 1ns/100ps
module mpio_props #(
	parameter int NUM_PORTS = 9,
	parameter int PORT_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe,
	input wire logic [NUM_PORTS*PORT_W-1:0] pullup_en,
	input wire logic [2*PORT_W-1:0] seg_data,
	input wire logic irq
);
	// ****************************************************************
	// Properties, all on clk
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	property p_in_only; ((pin_oe[7:0] | pullup_en[7:0]) & 8'hc1) == 8'h00; endproperty
	a_in_only: assert property (p_in_only) else $error("input-only pin driven or pulled");
	property p_pull_in; (pullup_en & pin_oe) == '0; endproperty
	a_pull_in: assert property (p_pull_in) else $error("pull-up on driven pin");
	property p_out_quiet; (pin_out & ~pin_oe) == '0; endproperty
	a_out_quiet: assert property (p_out_quiet) else $error("level on undriven pin");
	property p_dir0; wr && addr == 8'h10 |-> ##2 pin_oe[7:0] == (~$past(wdata, 2) & 8'h3e); endproperty
	a_dir0: assert property (p_dir0) else $error("port 0 direction");
	property p_dir1; wr && addr == 8'h11 |-> ##2 pin_oe[15:8] == ~$past(wdata, 2); endproperty
	a_dir1: assert property (p_dir1) else $error("port 1 direction");
	property p_latch1; wr && addr == 8'h01 |-> ##2 pin_out[15:8] == ($past(wdata, 2) & pin_oe[15:8]); endproperty
	a_latch1: assert property (p_latch1) else $error("port 1 latch");
	property p_pull1;
		wr && addr == 8'h20 |-> ##2 pullup_en[15:8] == ((($past(wdata, 2) & 8'h02) != 0) ? ~pin_oe[15:8] : 8'h00);
	endproperty
	a_pull1: assert property (p_pull1) else $error("port 1 pull-up group");
	property p_pull0;
		wr && addr == 8'h20 |-> ##2 pullup_en[5:1] == ((($past(wdata, 2) & 8'h01) != 0) ? ~pin_oe[5:1] : 5'h00);
	endproperty
	a_pull0: assert property (p_pull0) else $error("port 0 pull-up group");
	property p_seg; wr && addr == 8'h23 && wdata[0] |-> ##2 pin_oe[41:40] == 2'b11; endproperty
	a_seg: assert property (p_seg) else $error("segment pair not driven");
	property p_irq_off; wr && addr == 8'h26 && wdata == 8'h00 |-> ##2 !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt with all enables off");
endmodule : mpio_props

// *** mpio_pins_model.sv ***
// Outside circuitry on the port pins.
// Assumes one bit per pin, same order as the block's pin buses.
`timescale 1ns/100ps
module mpio_pins_model #(
	parameter int W = 72
) (
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] pullup_en,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_level,
	output logic [W-1:0] pin_in
);
	// Driver wins, then outside drive, then pull-up; a floating pin drifts off the last level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_level) | (~pin_oe & ~ext_en & (pullup_en | ~ext_level));
endmodule : mpio_pins_model

// *** tb_top.sv ***
// Testbench for the parallel port block.
// Assumes mpio_pkg, mpio_ports, the checker and the pin model are compiled first.
`timescale 1ns/100ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin err_total++; $display("unexpected at %0t: %s", $time, m); end end
module tb_top;
	localparam int W = mpio_pkg::NUM_PORTS * mpio_pkg::PORT_W;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, d;
	logic [W-1:0] pin_in, pin_out, pin_oe, pullup_en;
	logic [W-1:0] ext_en = {56'hff_ffff_ffff_ffff, 16'h00ff};
	logic [W-1:0] ext_level = {8'h01, 48'h0000_0000_0000, 16'hff00};
	logic [15:0] seg_data = 16'h5a3e;
	logic irq;
	int err_total = 0;
	int check_count = 0;
	mpio_ports dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .seg_data(seg_data), .irq(irq));
	mpio_pins_model #(.W(W)) pins (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_en(ext_en),
		.ext_level(ext_level), .pin_in(pin_in));
	// ****************************************************************
	// Bus tasks and run control
	// ****************************************************************
	initial forever #4 clk = ~clk;
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// Samples the line off the clock edge so a value launched at that edge is seen settled
	task automatic wait_irq(input logic v);
		#1;
		for (int k = 0; k < 20 && irq !== v; k++) begin
			@(posedge clk);
			#1;
		end
		`CHK(irq, v, "interrupt level")
		if (irq !== v) finish_test();
	endtask : wait_irq
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("unexpected at %0t: run timeout", $time);
		finish_test();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			rd_reg(8'h10 + 8'(i));
			`CHK(d & mpio_pkg::PIN_MASK[i], mpio_pkg::PIN_MASK[i], "direction reset")
		end
		`CHK(pin_oe | pullup_en, '0, "pins after reset")
		wr_reg(8'h30, 8'hff);
		rd_reg(8'h30);
		`CHK(d, 8'h00, "unmapped read")
		wr_reg(8'h10, 8'h00);
		rd_reg(8'h10);
		`CHK(d & 8'hbf, 8'h81, "input-only direction")
		`CHK(pin_oe[7:0], 8'h3e, "port 0 drivers")
		wr_reg(8'h25, 8'hff);
		wr_reg(8'h00, 8'hff);
		settle;
		rd_reg(8'h00);
		`CHK(d & 8'hbf, 8'h3e, "port 0 read")
		`CHK(pin_out[7:0], 8'h3e, "port 0 drive")
		rd_reg(8'h24);
		`CHK(d, 8'h3e, "output change flags")
		wr_reg(8'h25, 8'h3e);
		rd_reg(8'h24);
		`CHK(d, 8'h00, "flags cleared")
		wr_reg(8'h10, 8'hff);
		wr_reg(8'h20, 8'h03);
		settle;
		`CHK(pullup_en[15:0], 16'hff3e, "group pull-ups")
		wr_reg(8'h11, 8'h0f);
		wr_reg(8'h01, 8'ha5);
		settle;
		rd_reg(8'h01);
		`CHK(d, 8'haf, "mixed port 1 read")
		`CHK({pin_oe[15:8], pullup_en[15:8]}, 16'hf00f, "port 1 per-pin mode")
		// Falling edge on port 11 pin 0 raises the key flag
		wr_reg(8'h26, 8'h40);
		wr_reg(8'h22, 8'h01);
		ext_level[64] <= 1'b0;
		wait_irq(1'b1);
		rd_reg(8'h24);
		`CHK(d & 8'h40, 8'h40, "key flag")
		wr_reg(8'h26, 8'h00);
		wait_irq(1'b0);
		wr_reg(8'h26, 8'h40);
		wait_irq(1'b1);
		wr_reg(8'h25, 8'h7f);
		wait_irq(1'b0);
		wr_reg(8'h23, 8'h01);
		settle;
		`CHK({pin_oe[43:40], pin_out[41:40]}, {4'h3, seg_data[1:0]}, "segment pair")
		// Segment pair moves to port 9, port 8 pair returns to I/O; high pull-up group on port 11
		wr_reg(8'h23, 8'h10);
		wr_reg(8'h21, 8'h08);
		settle;
		`CHK({pin_oe[49:48], pin_out[49:48], pin_oe[41:40]}, {2'h3, seg_data[9:8], 2'h0}, "port 9 segment pair")
		`CHK({pullup_en[71:64], pullup_en[47:40]}, 16'hff00, "high group pull-ups")
		for (int i = 0; i < 9; i++) wr_reg(8'h10 + 8'(i), 8'h00);
		settle;
		`CHK($countones(pin_oe), 55, "driver count")
		reset <= 1'b1;
		settle;
		reset <= 1'b0;
		`CHK(pin_oe, '0, "mid-run reset")
		rd_reg(8'h11);
		`CHK(d, 8'hff, "direction after reset")
		finish_test();
	end
endmodule : tb_top
bind mpio_ports mpio_props #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) u_props (.clk(clk), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.pullup_en(pullup_en), .seg_data(seg_data), .irq(irq));
